// File: src/rtc_sram_pkg.sv
// constants for the battery-backed byte memory with calendar clock
// assumes a 40 MHz system clock; all bus pins are synchronised in two stages inside rtc_sram
package rtc_sram_pkg;
    localparam int          ADDR_W          = 15;
    localparam int          MEM_DEPTH       = 32768;
    localparam int          CLK_HZ          = 40000000;
    // clock byte offsets
    localparam logic [14:0] CLOCK_CONTROL   = 15'h7ff8;
    localparam logic [14:0] CLOCK_SECONDS   = 15'h7ff9;
    localparam logic [14:0] CLOCK_MINUTES   = 15'h7ffa;
    localparam logic [14:0] CLOCK_HOURS     = 15'h7ffb;
    localparam logic [14:0] CLOCK_DAY       = 15'h7ffc;
    localparam logic [14:0] CLOCK_DATE      = 15'h7ffd;
    localparam logic [14:0] CLOCK_MONTH     = 15'h7ffe;
    localparam logic [14:0] CLOCK_YEAR      = 15'h7fff;
    localparam logic [11:0] CLOCK_BASE_HI   = 12'hfff;
    // control byte fields
    localparam int          CTL_WRITE_BIT   = 7;
    localparam int          CTL_READ_BIT    = 6;
    localparam logic [7:0]  CTL_RESET       = 8'h00;
    // calendar reset values (bcd)
    localparam logic [7:0]  RST_SEC         = 8'h00;
    localparam logic [7:0]  RST_MIN         = 8'h00;
    localparam logic [7:0]  RST_HOUR        = 8'h00;
    localparam logic [7:0]  RST_DAY         = 8'h01;
    localparam logic [7:0]  RST_DATE        = 8'h01;
    localparam logic [7:0]  RST_MONTH       = 8'h01;
    localparam logic [7:0]  RST_YEAR        = 8'h00;
    // timing
    localparam int          SECOND_CYCLES   = CLK_HZ;
    localparam int          REC_MIN_MS      = 40;
    localparam int          REC_MAX_MS      = 200;
    localparam int          REC_MIN_CYCLES  = (REC_MIN_MS * (CLK_HZ / 1000));
    localparam int          FAST_FALL_US    = 200;
    localparam int          FAST_FALL_CYC   = (FAST_FALL_US * (CLK_HZ / 1000000));
endpackage

// File: src/bcd_digit_pair.sv
// one bcd counter byte with programmable wrap
// assumes a synchronous reset and a one-cycle advance pulse from the same clock
`timescale 1ns/1ps
module bcd_digit_pair
    import rtc_sram_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic [7:0] reset_val_in,
    input  wire logic [7:0] wrap_max_in,
    input  wire logic [7:0] wrap_to_in,
    input  wire logic       load_in,
    input  wire logic [7:0] load_val_in,
    input  wire logic       step_in,
    output logic      [7:0] value_out,
    output logic            carry_out
);
    typedef struct packed {
        logic [7:0] val;
    } state_t;
    state_t cur;
    state_t next_cur;

    // carry when stepping from the top value
    assign carry_out = step_in && (cur.val == wrap_max_in);
    assign value_out = cur.val;

    // bcd increment, low digit first
    always_comb begin
        next_cur = cur;
        if (load_in) begin
            next_cur.val = load_val_in;
        end else if (step_in) begin
            if (cur.val == wrap_max_in) begin
                next_cur.val = wrap_to_in;
            end else if (cur.val[3:0] >= 4'h9) begin
                next_cur.val = {cur.val[7:4] + 4'h1, 4'h0};
            end else begin
                next_cur.val = {cur.val[7:4], cur.val[3:0] + 4'h1};
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            cur.val <= reset_val_in;
        end else begin
            cur <= next_cur;
        end
    end
endmodule // bcd_digit_pair

// File: src/rtc_sram.sv
// byte-wide static memory with calendar clock in the top eight bytes
// assumes the asynchronous bus pins and supply-fail input arrive unsynchronised;
// the host keeps the select high during power-up as a good citizen
`timescale 1ns/1ps
// What this block does
// - a 15-bit address picks one of 32768 bytes per access
// - clock bytes live at 7ff8h through 7fffh in place of ordinary memory
// - clock bytes hold bcd year to seconds, 24-hour hours
// - month lengths of 28, 29 leap, 30 and 31 handled automatically
// - byte 7ff8h is the clock control byte
// - clock bytes are separate cells refreshed from counters once per second
// - clock bytes use the same bus strobes as any memory byte
// - writes are blocked while the supply is out of tolerance
// - read whenever write strobe high and select low
// - data lines driven only while select and output strobe are low
// - select and write strobe falling together keep outputs released
// - after supply returns, bus inputs ignored for 40 to 200 ms
// - fast supply fall may delay protection up to 200 us
// - write while select and write strobe low, ends at earlier rise
// - during power-fail deselect outputs released, inputs ignored
// - control bit d6 at one freezes the once-per-second refresh
module rtc_sram
    import rtc_sram_pkg::*;
#(
    parameter int RECOVERY_CYCLES = REC_MIN_CYCLES,
    parameter int TICK_CYCLES     = SECOND_CYCLES
) (
    input  wire logic        sys_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic [14:0] bus_address_lines_in,
    input  wire logic [7:0]  bus_data_lines_in,
    output logic      [7:0]  bus_data_lines_out,
    output logic             bus_data_lines_oe_out,
    input  wire logic        select_n_in,
    input  wire logic        write_n_in,
    input  wire logic        output_n_in,
    input  wire logic        supply_fail_in
);
    typedef struct packed {
        logic [14:0] adr_s1;
        logic [14:0] adr_s2;
        logic [7:0]  dat_s1;
        logic [7:0]  dat_s2;
        logic [3:0]  ctl_s1;
        logic [3:0]  ctl_s2;
        logic        wr_active;
        logic        rd_blank;
        logic [14:0] wr_addr;
        logic [7:0]  wr_data;
        logic        deselect;
        logic [31:0] rec_cnt;
        logic [31:0] tick_cnt;
        logic [7:0]  ctl_byte;
        logic [7:0]  rd_data;
        logic        oe;
        logic        refresh_due;
        logic [6:0][7:0] cells;
    } state_t;
    state_t cur;
    state_t next_cur;

    logic [7:0] mem [MEM_DEPTH];
    logic       commit;
    logic       mem_we;
    logic [7:0] mem_q;

    // synchronised view of the pins
    logic sel;
    logic wr;
    logic oen;
    logic fail;
    assign sel  = ~cur.ctl_s2[0];
    assign wr   = ~cur.ctl_s2[1];
    assign oen  = ~cur.ctl_s2[2];
    assign fail = cur.ctl_s2[3];

    // counters: sec, min, hour, day, date, month, year
    logic [7:0] cnt [7];
    logic [6:0] carry;
    logic [7:0] wmax [7];
    logic [7:0] wto [7];
    logic [7:0] rst [7];
    logic [7:0] month_last;
    logic       leap;
    logic       tick;
    logic       load_cnt;

    assign tick = (cur.tick_cnt == 32'(TICK_CYCLES - 1)) && !cur.ctl_byte[CTL_WRITE_BIT];
    // write bit falling loads counters from the cells
    assign load_cnt = cur.ctl_byte[CTL_WRITE_BIT] && commit
                      && (cur.wr_addr == CLOCK_CONTROL) && !cur.wr_data[CTL_WRITE_BIT];

    // leap year: bcd year divisible by four
    assign leap = (cnt[6][4] ? (cnt[6][1:0] == 2'b10) : (cnt[6][1:0] == 2'b00));
    always_comb begin
        unique case (cnt[5])
            8'h02:                      month_last = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
            default:                    month_last = 8'h31;
        endcase
    end
    assign wmax = '{8'h59, 8'h59, 8'h23, 8'h07, month_last, 8'h12, 8'h99};
    assign wto  = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
    assign rst  = '{RST_SEC, RST_MIN, RST_HOUR, RST_DAY, RST_DATE, RST_MONTH, RST_YEAR};

    // chain of bcd counters; day of week and date both step on the hour carry
    genvar g;
    generate
        for (g = 0; g < 7; g++) begin : g_cnt
            logic step;
            if (g == 0) begin : g_first
                assign step = tick;
            end else if (g == 4) begin : g_date
                assign step = carry[2];
            end else begin : g_rest
                assign step = carry[g - 1];
            end
            bcd_digit_pair u_pair (
                .sys_clk_in   (sys_clk_in),
                .sys_rst_in   (sys_rst_in),
                .reset_val_in (rst[g]),
                .wrap_max_in  (wmax[g]),
                .wrap_to_in   (wto[g]),
                .load_in      (load_cnt),
                .load_val_in  (cur.cells[g] & 8'h7f),
                .step_in      (step),
                .value_out    (cnt[g]),
                .carry_out    (carry[g])
            );
        end
    endgenerate

    // write ends at the earlier rising strobe; blocked during fail or recovery
    assign commit = cur.wr_active && !(sel && wr) && !cur.deselect;
    assign mem_we = commit && (cur.wr_addr[14:3] != CLOCK_BASE_HI);

    always_comb begin
        next_cur = cur;
        next_cur.adr_s1 = bus_address_lines_in;
        next_cur.adr_s2 = cur.adr_s1;
        next_cur.dat_s1 = bus_data_lines_in;
        next_cur.dat_s2 = cur.dat_s1;
        next_cur.ctl_s1 = {supply_fail_in, output_n_in, write_n_in, select_n_in};
        next_cur.ctl_s2 = cur.ctl_s1;
        // deselect on fail, then hold off for the recovery time
        if (fail) begin
            next_cur.deselect = 1'b1;
            next_cur.rec_cnt  = 32'h0;
        end else if (cur.deselect) begin
            if (cur.rec_cnt == 32'(RECOVERY_CYCLES - 1)) begin
                next_cur.deselect = 1'b0;
            end
            next_cur.rec_cnt = cur.rec_cnt + 32'h1;
        end
        // write tracking; data latched through the whole low phase
        if (sel && wr && !cur.deselect) begin
            next_cur.wr_active = 1'b1;
            next_cur.wr_addr   = cur.adr_s2;
            next_cur.wr_data   = cur.dat_s2;
        end else begin
            next_cur.wr_active = 1'b0;
        end
        // simultaneous select and write fall blanks outputs for the access
        if (!sel) begin
            next_cur.rd_blank = 1'b0;
        end else if (!cur.oe && wr && !cur.wr_active) begin
            next_cur.rd_blank = 1'b1;
        end
        // read path, same strobes for clock bytes and memory
        if (cur.adr_s2[14:3] == CLOCK_BASE_HI) begin
            next_cur.rd_data = (cur.adr_s2 == CLOCK_CONTROL) ? cur.ctl_byte
                               : cur.cells[3'(cur.adr_s2[2:0] - 3'h1)];
        end else begin
            next_cur.rd_data = mem_q;
        end
        next_cur.oe = sel && !wr && oen && !cur.deselect && !next_cur.rd_blank;
        // once-per-second refresh unless frozen
        next_cur.tick_cnt = tick ? 32'h0 :
                            (cur.ctl_byte[CTL_WRITE_BIT] ? cur.tick_cnt : cur.tick_cnt + 32'h1);
        // refresh one cycle after the tick so the cells see the stepped count
        next_cur.refresh_due = tick;
        if (cur.refresh_due) begin
            if (!cur.ctl_byte[CTL_READ_BIT] && !cur.ctl_byte[CTL_WRITE_BIT]) begin
                for (int i = 0; i < 7; i++) begin
                    next_cur.cells[i] = cnt[i];
                end
            end
        end
        // host writes to clock cells and control byte
        if (commit && (cur.wr_addr[14:3] == CLOCK_BASE_HI)) begin
            if (cur.wr_addr == CLOCK_CONTROL) begin
                next_cur.ctl_byte = cur.wr_data;
            end else begin
                next_cur.cells[3'(cur.wr_addr[2:0] - 3'h1)] = cur.wr_data;
            end
        end
        // fail ends any write without committing
        if (fail) begin
            next_cur.wr_active = 1'b0;
            next_cur.oe        = 1'b0;
        end
    end

    // memory array write port
    always_ff @(posedge sys_clk_in) begin
        if (mem_we) begin
            mem[cur.wr_addr] <= cur.wr_data;
        end
    end

    // read only from the second stage; the first may still be settling
    assign mem_q = mem[cur.adr_s2];

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            cur.adr_s1    <= 15'h0000;
            cur.adr_s2    <= 15'h0000;
            cur.dat_s1    <= 8'h00;
            cur.dat_s2    <= 8'h00;
            cur.ctl_s1    <= 4'h7;
            cur.ctl_s2    <= 4'h7;
            cur.wr_active <= 1'b0;
            cur.rd_blank  <= 1'b0;
            cur.wr_addr   <= 15'h0000;
            cur.wr_data   <= 8'h00;
            cur.deselect  <= 1'b1;
            cur.rec_cnt   <= 32'h0;
            cur.tick_cnt  <= 32'h0;
            cur.ctl_byte  <= CTL_RESET;
            cur.rd_data   <= 8'h00;
            cur.oe        <= 1'b0;
            cur.refresh_due <= 1'b0;
            cur.cells     <= {RST_YEAR, RST_MONTH, RST_DATE, RST_DAY, RST_HOUR,
                              RST_MIN, RST_SEC};
        end else begin
            cur <= next_cur;
        end
    end

    assign bus_data_lines_out    = cur.rd_data;
    assign bus_data_lines_oe_out = cur.oe;
endmodule // rtc_sram

// File: bench/rtc_sram_asserts.sv
// checker for the bus side of the clock memory
// assumes binding onto rtc_sram, sync reset active high
`timescale 1ns/1ps
module rtc_sram_asserts #(
    parameter int RECOVERY_CYCLES = 50
) (
    input wire logic        sys_clk_in,
    input wire logic        sys_rst_in,
    input wire logic [14:0] bus_address_lines_in,
    input wire logic [7:0]  bus_data_lines_in,
    input wire logic [7:0]  bus_data_lines_out,
    input wire logic        bus_data_lines_oe_out,
    input wire logic        select_n_in,
    input wire logic        write_n_in,
    input wire logic        output_n_in,
    input wire logic        supply_fail_in
);
    int   quiet_cnt;
    logic rd_req;
    // cycles since reset or supply loss, saturating so it never wraps
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in || supply_fail_in) begin
            quiet_cnt <= 0;
        end else if (quiet_cnt < RECOVERY_CYCLES + 8) begin
            quiet_cnt <= quiet_cnt + 1;
        end
    end
    // margin of 8 covers the two-stage synchronisers
    assign rd_req = !select_n_in && !output_n_in && write_n_in && !supply_fail_in
                    && (quiet_cnt >= RECOVERY_CYCLES + 8);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    a_read_drives: assert property (select_n_in ##1 rd_req [*6] |-> bus_data_lines_oe_out)
        else $error("read access not driven");
    a_desel_release: assert property (select_n_in [*4] |-> !bus_data_lines_oe_out)
        else $error("driving while deselected");
    a_strobe_release: assert property (output_n_in [*4] |-> !bus_data_lines_oe_out)
        else $error("driving without output strobe");
    a_fail_release: assert property (supply_fail_in [*4] |-> !bus_data_lines_oe_out)
        else $error("driving during supply loss");
    a_write_quiet: assert property (!write_n_in [*5] |-> !bus_data_lines_oe_out)
        else $error("driving during write");
    a_recovery_quiet: assert property (quiet_cnt < RECOVERY_CYCLES |-> !bus_data_lines_oe_out)
        else $error("driving during recovery");
    a_together_quiet: assert property ($fell(select_n_in) && $fell(write_n_in) ##1
        !select_n_in [*7] |-> !bus_data_lines_oe_out)
        else $error("driving after joint fall");
    a_reset_clear: assert property ($past(sys_rst_in) |-> !bus_data_lines_oe_out
        && bus_data_lines_out == 8'h00)
        else $error("outputs not cleared by reset");
endmodule // rtc_sram_asserts

bind rtc_sram rtc_sram_asserts #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) rtc_sram_asserts_inst (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .bus_address_lines_in(bus_address_lines_in), .bus_data_lines_in(bus_data_lines_in),
    .bus_data_lines_out(bus_data_lines_out), .bus_data_lines_oe_out(bus_data_lines_oe_out),
    .select_n_in(select_n_in), .write_n_in(write_n_in), .output_n_in(output_n_in),
    .supply_fail_in(supply_fail_in));

// File: bench/rtc_host_model.sv
// host processor model on the asynchronous memory bus
// assumes its tasks are entered just after a rising clock edge
`timescale 1ns/1ps
module rtc_host_model (
    input  wire logic        sys_clk_in,
    input  wire logic [7:0]  data_in,
    input  wire logic        oe_in,
    output logic      [14:0] addr_out,
    output logic      [7:0]  data_out,
    output logic             select_n_out,
    output logic             write_n_out,
    output logic             output_n_out
);
    // idle: deselected during power-up
    initial begin
        addr_out = 15'h0000;
        data_out = 8'h00;
        select_n_out = 1'b1;
        write_n_out = 1'b1;
        output_n_out = 1'b1;
    end
    // strobes held 4 clocks so the synchronisers see the write
    task automatic write_byte(input logic [14:0] a, input logic [7:0] d);
        addr_out = a;
        data_out = d;
        select_n_out = 1'b0;
        write_n_out = 1'b0;
        repeat (4) @(posedge sys_clk_in);
        #2;
        select_n_out = 1'b1;
        write_n_out = 1'b1;
        repeat (2) @(posedge sys_clk_in);
        #2;
        data_out = ~d; // released lines show no stale value
        @(posedge sys_clk_in);
        #2;
    endtask
    // read window of 10 clocks; wr_too pulls the write strobe with select
    task automatic read_byte(input logic [14:0] a, input logic wr_too,
                             output logic [7:0] d, output logic drove);
        addr_out = a;
        select_n_out = 1'b0;
        output_n_out = 1'b0;
        write_n_out = ~wr_too;
        drove = 1'b0;
        d = 8'h00;
        for (int i = 0; i < 10; i++) begin
            @(posedge sys_clk_in);
            #2;
            // joint fall: lift the write strobe while select stays low
            if (wr_too && i == 3) begin
                write_n_out = 1'b1;
            end
            if (!drove && oe_in === 1'b1) begin
                drove = 1'b1;
                d = data_in;
            end
        end
        select_n_out = 1'b1;
        output_n_out = 1'b1;
        write_n_out = 1'b1;
        repeat (4) @(posedge sys_clk_in);
        #2;
    endtask
endmodule // rtc_host_model

// File: bench/tb_battery_backed_sram_rtc_bus.sv
// self-checking bench for the clock memory
// assumes the host model and checker are compiled before it
`timescale 1ns/1ps
module tb_battery_backed_sram_rtc_bus;
    import rtc_sram_pkg::*;
    localparam int REC  = 50;
    localparam int TICK = 40;
    typedef struct packed {logic [14:0] a; logic [7:0] d;} row_t;
    logic        sys_clk_in, sys_rst_in, supply_fail_in;
    logic [14:0] addr;
    logic [7:0]  host_data, dout, dq, rd, s1;
    logic        oe, sel_n, wr_n, out_n, seen;
    int          fails, num_checks;
    row_t        rows [5] = '{'{15'h0000, 8'h5a}, '{15'h0001, 8'hc3}, '{15'h4000, 8'ha5},
                              '{15'h7ff7, 8'h3c}, '{15'h7ffb, 8'h12}};
    logic [7:0]  yrs [2] = '{8'h01, 8'h04};
    logic [7:0]  dates [2] = '{8'h01, 8'h29};
    logic [7:0]  months [2] = '{8'h03, 8'h02};
    // shared data wire: device wins while it drives
    assign dq = oe ? dout : host_data;
    rtc_sram #(.RECOVERY_CYCLES(REC), .TICK_CYCLES(TICK)) rtc_sram_inst (
        .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .bus_address_lines_in(addr),
        .bus_data_lines_in(dq), .bus_data_lines_out(dout), .bus_data_lines_oe_out(oe),
        .select_n_in(sel_n), .write_n_in(wr_n), .output_n_in(out_n),
        .supply_fail_in(supply_fail_in));
    rtc_host_model rtc_host_model_inst (
        .sys_clk_in(sys_clk_in), .data_in(dq), .oe_in(oe), .addr_out(addr),
        .data_out(host_data), .select_n_out(sel_n), .write_n_out(wr_n),
        .output_n_out(out_n));
    initial begin
        sys_clk_in = 1'b0;
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end
    task automatic check(input string name, input logic [7:0] seen_v, input logic [7:0] exp_v);
        num_checks++;
        if (seen_v !== exp_v) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp_v, seen_v);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #2;
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        rtc_host_model_inst.write_byte(a, d);
    endtask
    // a read must be driven and carry the expected byte
    task automatic rd_chk(input string name, input logic [14:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       drv;
        rtc_host_model_inst.read_byte(a, 1'b0, d, drv);
        check(name, {7'h00, drv}, 8'h01);
        check(name, d, e);
    endtask
    initial begin
        sys_rst_in = 1'b1;
        supply_fail_in = 1'b0;
        fails = 0;
        num_checks = 0;
        tick(3);
        sys_rst_in = 1'b0;
        tick(REC + 8);
        rd_chk("control reset", CLOCK_CONTROL, CTL_RESET);
        wr(CLOCK_CONTROL, 8'h40);
        rd_chk("control rw", CLOCK_CONTROL, 8'h40);
        foreach (rows[i]) wr(rows[i].a, rows[i].d);
        foreach (rows[i]) rd_chk("row data", rows[i].a, rows[i].d);
        $display("test table done");
        // frozen cells must not move; released cells must
        rtc_host_model_inst.read_byte(CLOCK_SECONDS, 1'b0, s1, seen);
        tick(3 * TICK);
        rd_chk("frozen seconds", CLOCK_SECONDS, s1);
        wr(CLOCK_CONTROL, 8'h00);
        tick(3 * TICK);
        rtc_host_model_inst.read_byte(CLOCK_SECONDS, 1'b0, rd, seen);
        check("refresh", {7'h00, rd !== s1}, 8'h01);
        $display("test refresh done");
        // 23:59:59 on the 28th of february, plain and leap year
        for (int i = 0; i < 2; i++) begin
            wr(CLOCK_CONTROL, 8'h80);
            wr(CLOCK_SECONDS, 8'h59);
            wr(CLOCK_MINUTES, 8'h59);
            wr(CLOCK_HOURS, 8'h23);
            wr(CLOCK_DATE, 8'h28);
            wr(CLOCK_MONTH, 8'h02);
            wr(CLOCK_YEAR, yrs[i]);
            wr(CLOCK_CONTROL, 8'h00);
            tick(TICK + 10);
            wr(CLOCK_CONTROL, 8'h40);
            rd_chk("date", CLOCK_DATE, dates[i]);
            rd_chk("month", CLOCK_MONTH, months[i]);
            rd_chk("hours", CLOCK_HOURS, 8'h00);
        end
        $display("test calendar done");
        supply_fail_in = 1'b1;
        tick(4);
        wr(15'h0000, 8'hff);
        rtc_host_model_inst.read_byte(15'h0000, 1'b0, rd, seen);
        check("fail drive", {7'h00, seen}, 8'h00);
        supply_fail_in = 1'b0;
        tick(4);
        rtc_host_model_inst.read_byte(15'h0000, 1'b0, rd, seen);
        check("recovery drive", {7'h00, seen}, 8'h00);
        tick(REC + 8);
        rd_chk("fail write", 15'h0000, 8'h5a);
        rtc_host_model_inst.read_byte(15'h2000, 1'b1, rd, seen);
        check("joint fall drive", {7'h00, seen}, 8'h00);
        $display("test power done");
        stop_test();
    end
endmodule // tb_battery_backed_sram_rtc_bus
